//--- rtl/pwrt_pkg.sv
// Constants and types shared by the periodic wakeup and reset timer
package pwrt_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] WAKEUP_CTRL_STATUS_OFS        = 12'h000;
  localparam logic [11:0] RESET_INTERVAL_CTRL_STATUS_OFS = 12'h004;
  localparam logic [11:0] COUNTER_READBACK_STATUS_OFS   = 12'h008;
  localparam logic [11:0] WAKEUP_PRESCALE_SELECT_OFS    = 12'h00C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int FLAG_BIT      = 7;
  localparam int ACK_BIT       = 6;
  localparam int PAGE_BIT      = 7;
  localparam int FIELD_MSB     = 5;
  localparam int FIELD_W       = 6;

  // ----------------------------------------------------------------
  // Values after reset, and the forced wakeup limit
  // ----------------------------------------------------------------
  localparam logic [5:0] INTERVAL_RESET      = 6'h3F;
  localparam logic [5:0] PRESCALE_RESET      = 6'h1F;
  localparam logic [5:0] WAKEUP_FORCED_LIMIT = 6'h3F;
  localparam logic [5:0] COUNT_ZERO          = 6'h00;

  // ----------------------------------------------------------------
  // Prescaler: period = PRESCALE_BASE + (select << PRESCALE_SHIFT), in 1 ms ticks
  // ----------------------------------------------------------------
  localparam int          LFO_PERIOD_US  = 1000;
  localparam int          CLK_PERIOD_NS  = 20;
  localparam logic [10:0] PRESCALE_BASE  = 11'h1F8;
  localparam int          PRESCALE_SHIFT = 4;
  localparam logic [10:0] PRESCALE_ZERO  = 11'h000;

  typedef enum logic [1:0] {
    PWRT_RUN,
    PWRT_CLOCK_GATED_STOP,
    PWRT_POWER_DOWN_STOP
  } pwrt_mode_t;

endpackage : pwrt_pkg

//--- rtl/pwrt_cnt_if.sv
// Carrier between the timer core and one interval counter
`timescale 1ns/1ps
interface pwrt_cnt_if;
  logic       tick;
  logic       restart;
  logic       freeze;
  logic [5:0] limit;
  logic [5:0] count;
  logic       done;

  modport ctrl (output tick, output restart, output freeze, output limit,
                input count, input done);
  modport cnt  (input tick, input restart, input freeze, input limit,
                output count, output done);
endinterface : pwrt_cnt_if

//--- rtl/pwrt_counter.sv
// Six-bit interval counter that pulses done when it reaches its limit
`timescale 1ns/1ps
module pwrt_counter (
  input wire logic pclk,
  input wire logic presetn,
  pwrt_cnt_if.cnt  bus
);

  logic [5:0] count_r;
  logic [5:0] count_nxt;
  logic       done_r;

  // ----------------------------------------------------------------
  // Counting
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= pwrt_pkg::COUNT_ZERO;
      done_r  <= 1'b0;
    end else if (bus.restart) begin
      count_r <= pwrt_pkg::COUNT_ZERO;
      done_r  <= 1'b0;
    end else if (bus.tick && !bus.freeze && bus.limit != pwrt_pkg::COUNT_ZERO) begin
      if (count_nxt >= bus.limit) begin
        count_r <= pwrt_pkg::COUNT_ZERO;
        done_r  <= 1'b1;
      end else begin
        count_r <= count_nxt;
        done_r  <= 1'b0;
      end
    end else begin
      done_r <= 1'b0;
    end
  end

  assign count_nxt  = count_r + 6'h01;
  assign bus.count  = count_r;
  assign bus.done   = done_r;

endmodule : pwrt_counter

//--- rtl/pwrt_top.sv
// Periodic wakeup and periodic reset timer with APB register access
//
// What this block does
// - Periodic reset flag at bit 7 sets on each periodic reset; writes ignored.
// - Periodic reset flag clears only by power-on reset or acknowledge.
// - Writing one to ack bit 6 clears the flag; reads zero.
// - Six-bit reset interval: wakeup periods needed per periodic reset, 1 to 63.
// - Writing a changed reset interval restarts counting; same value does nothing.
// - Zero reset interval disables periodic reset while wakeup interval nonzero.
// - Zero reset interval write rejected while wakeup interval is zero.
// - Every reset source presets the reset interval to 63.
// - Reading counter readback captures the selected counter at the read.
// - Page bit 7 selects wakeup counter (0) or reset counter (1).
// - Page bit cleared by power-on reset only, other resets keep it.
// - Bit 6 of counter readback always reads zero.
// - Readback field is read-only, reads zero right after the selected counter's own flag event.
// - Run mode: wakeup sets wakeup flag and raises the wakeup interrupt.
// - Run mode: periodic reset sets its flag and requests reset; registers kept.
// - Clock-gated stop: wakeup restarts clocks, sets flag, raises interrupt.
// - Clock-gated stop: periodic reset restarts clocks, sets flag, requests reset.
// - Power-down stop: wakeup exits as power-on, interrupt left pending.
// - Power-down stop: periodic reset exits as power-on, reset source shows power-on only.
// - Power-down stop exit keeps all timer registers.
// - Counters freeze during debug halt, resume afterwards.
// - Each wakeup period clocks the periodic reset counter.
// - Wakeup flag clears on acknowledge write or any reset, but a wakeup in the same cycle wins; zero write no effect.
`timescale 1ns/1ps
module pwrt_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lfo_clk,
  input  wire logic        other_reset,
  input  wire logic        clock_gated_stop_mode,
  input  wire logic        power_down_stop_mode,
  input  wire logic        background_debug_halt,
  output logic             wakeup_irq,
  output logic             periodic_reset_req,
  output logic             clock_restart_req,
  output logic             power_on_exit_req,
  output logic             system_reset_source_por_only
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pwrt_cnt_if wake_cnt ();
  pwrt_cnt_if rst_cnt ();

  logic [2:0]  lfo_sync_r;
  logic        lfo_level_r;
  logic        lfo_tick;
  logic [10:0] presc_r;
  logic [10:0] presc_end;
  logic        wclk_tick_r;

  logic        wakeup_flag_r;
  logic [5:0]  wakeup_interval_count_r;
  logic        periodic_reset_flag_r;
  logic [5:0]  reset_interval_count_r;
  logic        page_select_r;
  logic [5:0]  wakeup_prescale_select_r;

  logic [31:0] prdata_r;
  logic        pslverr_r;
  logic        pready_r;
  logic        wakeup_irq_r;
  logic        periodic_reset_req_r;
  logic        clock_restart_req_r;
  logic        power_on_exit_req_r;
  logic        srs_por_only_r;

  logic        setup;
  logic        access;
  logic        wr_en;
  logic        wr_wake;
  logic        wr_rst;
  logic        wr_page;
  logic        wr_presc;
  logic [5:0]  wr_field;
  logic        wake_restart;
  logic        rst_restart;
  logic        freeze;
  pwrt_pkg::pwrt_mode_t mode;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] ofs);
    addr_hit = (a[11:2] == ofs[11:2]);
  endfunction : addr_hit

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = addr_hit(a, pwrt_pkg::WAKEUP_CTRL_STATUS_OFS)
               || addr_hit(a, pwrt_pkg::RESET_INTERVAL_CTRL_STATUS_OFS)
               || addr_hit(a, pwrt_pkg::COUNTER_READBACK_STATUS_OFS)
               || addr_hit(a, pwrt_pkg::WAKEUP_PRESCALE_SELECT_OFS);
  endfunction : addr_mapped

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign wr_en    = access && pwrite && pstrb[0];
  assign wr_wake  = wr_en && addr_hit(paddr, pwrt_pkg::WAKEUP_CTRL_STATUS_OFS);
  assign wr_rst   = wr_en && addr_hit(paddr, pwrt_pkg::RESET_INTERVAL_CTRL_STATUS_OFS);
  assign wr_page  = wr_en && addr_hit(paddr, pwrt_pkg::COUNTER_READBACK_STATUS_OFS);
  assign wr_presc = wr_en && addr_hit(paddr, pwrt_pkg::WAKEUP_PRESCALE_SELECT_OFS);
  assign wr_field = pwdata[pwrt_pkg::FIELD_MSB:0];
  assign freeze   = background_debug_halt;

  always_comb begin
    if (power_down_stop_mode) begin
      mode = pwrt_pkg::PWRT_POWER_DOWN_STOP;
    end else if (clock_gated_stop_mode) begin
      mode = pwrt_pkg::PWRT_CLOCK_GATED_STOP;
    end else begin
      mode = pwrt_pkg::PWRT_RUN;
    end
  end

  // ----------------------------------------------------------------
  // Low-frequency oscillator synchroniser and 1 ms tick
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfo_sync_r <= 3'h0;
    end else begin
      lfo_sync_r <= {lfo_sync_r[1:0], lfo_clk};
    end
  end

  // Level follows only once the two late stages agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfo_level_r <= 1'b0;
    end else if (lfo_sync_r[1] == lfo_sync_r[2]) begin
      lfo_level_r <= lfo_sync_r[2];
    end
  end

  assign lfo_tick = (lfo_sync_r[1] == lfo_sync_r[2]) && lfo_sync_r[2] && !lfo_level_r;

  // ----------------------------------------------------------------
  // Wakeup clock prescaler
  // ----------------------------------------------------------------
  assign presc_end = pwrt_pkg::PRESCALE_BASE
                   + {1'b0, wakeup_prescale_select_r, 4'h0} - 11'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r     <= pwrt_pkg::PRESCALE_ZERO;
      wclk_tick_r <= 1'b0;
    end else if (other_reset) begin
      presc_r     <= pwrt_pkg::PRESCALE_ZERO;
      wclk_tick_r <= 1'b0;
    end else if (lfo_tick && !freeze) begin
      if (presc_r >= presc_end) begin
        presc_r     <= pwrt_pkg::PRESCALE_ZERO;
        wclk_tick_r <= 1'b1;
      end else begin
        presc_r     <= presc_r + 11'h001;
        wclk_tick_r <= 1'b0;
      end
    end else begin
      wclk_tick_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wakeup and periodic reset counters
  // ----------------------------------------------------------------
  assign wake_restart = other_reset
                     || (wr_wake && wr_field != wakeup_interval_count_r
                         && !(wr_field == pwrt_pkg::COUNT_ZERO
                              && reset_interval_count_r == pwrt_pkg::COUNT_ZERO));
  assign rst_restart  = other_reset
                     || (wr_rst && wr_field != reset_interval_count_r
                         && !(wr_field == pwrt_pkg::COUNT_ZERO
                              && wakeup_interval_count_r == pwrt_pkg::COUNT_ZERO));

  assign wake_cnt.tick    = wclk_tick_r;
  assign wake_cnt.restart = wake_restart;
  assign wake_cnt.freeze  = freeze;
  // Disabled wakeup still runs the divider at its forced limit to clock the reset counter
  assign wake_cnt.limit   = (wakeup_interval_count_r == pwrt_pkg::COUNT_ZERO)
                          ? pwrt_pkg::WAKEUP_FORCED_LIMIT : wakeup_interval_count_r;

  assign rst_cnt.tick     = wake_cnt.done;
  assign rst_cnt.restart  = rst_restart;
  assign rst_cnt.freeze   = freeze;
  assign rst_cnt.limit    = reset_interval_count_r;

  pwrt_counter u_wake_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (wake_cnt.cnt)
  );

  pwrt_counter u_reset_counter (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (rst_cnt.cnt)
  );

  // ----------------------------------------------------------------
  // Wakeup control: flag and interval
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_flag_r <= 1'b0;
    end else if (wake_cnt.done && wakeup_interval_count_r != pwrt_pkg::COUNT_ZERO) begin
      wakeup_flag_r <= 1'b1;
    end else if (other_reset) begin
      wakeup_flag_r <= 1'b0;
    end else if (wr_wake && pwdata[pwrt_pkg::ACK_BIT]) begin
      wakeup_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_interval_count_r <= pwrt_pkg::INTERVAL_RESET;
    end else if (other_reset) begin
      wakeup_interval_count_r <= pwrt_pkg::INTERVAL_RESET;
    end else if (wr_wake && !(wr_field == pwrt_pkg::COUNT_ZERO
                              && reset_interval_count_r == pwrt_pkg::COUNT_ZERO)) begin
      wakeup_interval_count_r <= wr_field;
    end
  end

  // ----------------------------------------------------------------
  // Periodic reset control: flag and interval
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_reset_flag_r <= 1'b0;
    end else if (rst_cnt.done) begin
      periodic_reset_flag_r <= 1'b1;
    end else if (wr_rst && pwdata[pwrt_pkg::ACK_BIT]) begin
      periodic_reset_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_interval_count_r <= pwrt_pkg::INTERVAL_RESET;
    end else if (other_reset) begin
      reset_interval_count_r <= pwrt_pkg::INTERVAL_RESET;
    end else if (wr_rst && !(wr_field == pwrt_pkg::COUNT_ZERO
                             && wakeup_interval_count_r == pwrt_pkg::COUNT_ZERO)) begin
      reset_interval_count_r <= wr_field;
    end
  end

  // ----------------------------------------------------------------
  // Readback page select and prescaler select
  // ----------------------------------------------------------------
  // Power-down stop exit is not presetn, so values survive it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_select_r <= 1'b0;
    end else if (wr_page) begin
      page_select_r <= pwdata[pwrt_pkg::PAGE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_prescale_select_r <= pwrt_pkg::PRESCALE_RESET;
    end else if (wr_presc) begin
      wakeup_prescale_select_r <= wr_field;
    end
  end

  // ----------------------------------------------------------------
  // APB read data and error
  // ----------------------------------------------------------------
  // Read data captured in the setup cycle, held through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= !addr_mapped(paddr);
      if (pwrite || !addr_mapped(paddr)) begin
        prdata_r <= 32'h0000_0000;
      end else if (addr_hit(paddr, pwrt_pkg::WAKEUP_CTRL_STATUS_OFS)) begin
        prdata_r <= {24'h00_0000, wakeup_flag_r, 1'b0, wakeup_interval_count_r};
      end else if (addr_hit(paddr, pwrt_pkg::RESET_INTERVAL_CTRL_STATUS_OFS)) begin
        prdata_r <= {24'h00_0000, periodic_reset_flag_r, 1'b0,
                     reset_interval_count_r};
      end else if (addr_hit(paddr, pwrt_pkg::COUNTER_READBACK_STATUS_OFS)) begin
        prdata_r <= {24'h00_0000, page_select_r, 1'b0,
                     page_select_r ? rst_cnt.count : wake_cnt.count};
      end else begin
        prdata_r <= {26'h000_0000, wakeup_prescale_select_r};
      end
    end else begin
      pslverr_r <= 1'b0;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ----------------------------------------------------------------
  // Requests towards core, interrupt controller and reset logic
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wakeup_irq_r <= 1'b0;
    end else begin
      wakeup_irq_r <= wakeup_flag_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_reset_req_r <= 1'b0;
      clock_restart_req_r  <= 1'b0;
      power_on_exit_req_r  <= 1'b0;
      srs_por_only_r       <= 1'b0;
      pready_r             <= 1'b0;
    end else begin
      pready_r             <= 1'b1;
      periodic_reset_req_r <= 1'b0;
      clock_restart_req_r  <= 1'b0;
      power_on_exit_req_r  <= 1'b0;
      srs_por_only_r       <= 1'b0;
      case (mode)
        pwrt_pkg::PWRT_RUN: begin
          periodic_reset_req_r <= rst_cnt.done;
        end
        pwrt_pkg::PWRT_CLOCK_GATED_STOP: begin
          clock_restart_req_r  <= rst_cnt.done || wakeup_event();
          periodic_reset_req_r <= rst_cnt.done;
        end
        pwrt_pkg::PWRT_POWER_DOWN_STOP: begin
          power_on_exit_req_r  <= rst_cnt.done || wakeup_event();
          srs_por_only_r       <= rst_cnt.done || wakeup_event();
        end
        default: periodic_reset_req_r <= 1'b0;
      endcase
    end
  end

  function automatic logic wakeup_event();
    wakeup_event = wake_cnt.done && (wakeup_interval_count_r != pwrt_pkg::COUNT_ZERO);
  endfunction : wakeup_event

  assign wakeup_irq                   = wakeup_irq_r;
  assign periodic_reset_req           = periodic_reset_req_r;
  assign clock_restart_req            = clock_restart_req_r;
  assign power_on_exit_req            = power_on_exit_req_r;
  assign system_reset_source_por_only = srs_por_only_r;

endmodule : pwrt_top

//--- test/pwrt_assertions.sv
// Concurrent checks on the timer's mode outputs and register reads
`timescale 1ns/1ps
module pwrt_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic        clock_gated_stop_mode,
  input wire logic        power_down_stop_mode,
  input wire logic        background_debug_halt,
  input wire logic        wakeup_irq,
  input wire logic        periodic_reset_req,
  input wire logic        clock_restart_req,
  input wire logic        power_on_exit_req,
  input wire logic        system_reset_source_por_only
);
  logic rd_acc;
  assign rd_acc = psel && penable && !pwrite;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_PRR_NOT_PD: assert property (periodic_reset_req |-> !$past(power_down_stop_mode))
    else $error("reset request in power-down stop");
  AST_POE_MODE: assert property (power_on_exit_req |-> $past(power_down_stop_mode))
    else $error("power-on exit outside power-down stop");
  AST_POR_PAIR: assert property (system_reset_source_por_only == power_on_exit_req)
    else $error("reset source flag not paired with exit");
  AST_CRQ_MODE: assert property (clock_restart_req |->
    $past(clock_gated_stop_mode) && !$past(power_down_stop_mode))
    else $error("clock restart outside clock-gated stop");
  AST_CG_RST_CRQ: assert property (periodic_reset_req && $past(clock_gated_stop_mode)
    |-> clock_restart_req)
    else $error("reset in clock-gated stop without restart");
  AST_CG_WAKE_CRQ: assert property ($rose(wakeup_irq) && $past(clock_gated_stop_mode, 2)
    && !$past(power_down_stop_mode, 2) |-> $past(clock_restart_req))
    else $error("wakeup in clock-gated stop without restart");
  AST_PRR_PULSE: assert property (periodic_reset_req |=> !periodic_reset_req [*8])
    else $error("reset request not a single pulse");
  AST_DBG_FREEZE: assert property (background_debug_halt [*6]
    |-> !periodic_reset_req && !$rose(wakeup_irq))
    else $error("event while debug halted");
  AST_ACK_RD0: assert property (rd_acc && (paddr == pwrt_pkg::WAKEUP_CTRL_STATUS_OFS
    || paddr == pwrt_pkg::RESET_INTERVAL_CTRL_STATUS_OFS)
    |-> prdata[6] == 1'b0 && prdata[31:8] == 24'h000000)
    else $error("ack bit read back nonzero");
  AST_RB_BIT6: assert property (rd_acc && paddr == pwrt_pkg::COUNTER_READBACK_STATUS_OFS
    |-> prdata[6] == 1'b0)
    else $error("readback bit 6 nonzero");

  cover property ($rose(wakeup_irq));
  cover property (periodic_reset_req);
  cover property (clock_restart_req);
  cover property (power_on_exit_req);
endmodule : pwrt_assertions

bind pwrt_top pwrt_assertions pwrt_assertions_inst (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .clock_gated_stop_mode, .power_down_stop_mode, .background_debug_halt,
  .wakeup_irq, .periodic_reset_req, .clock_restart_req, .power_on_exit_req,
  .system_reset_source_por_only);

//--- test/pwrt_far.sv
// Far-side model: free-running scaled oscillator (240 ns period) and counts of core events
`timescale 1ns/1ps
module pwrt_far (
  input  wire logic pclk,
  input  wire logic wakeup_irq,
  input  wire logic periodic_reset_req,
  input  wire logic clock_restart_req,
  input  wire logic power_on_exit_req,
  output logic      lfo_clk
);
  int   n_irq = 0;
  int   n_prr = 0;
  int   n_clk = 0;
  int   n_por = 0;
  logic irq_q = 1'b0;
  // Scaled oscillator, off the pclk edges
  initial begin
    lfo_clk = 1'b0;
    #7;
    forever #120 lfo_clk = ~lfo_clk;
  end
  always @(posedge pclk) begin
    irq_q <= wakeup_irq;
    if (wakeup_irq && !irq_q) n_irq <= n_irq + 1;
    if (periodic_reset_req) n_prr <= n_prr + 1;
    if (clock_restart_req) n_clk <= n_clk + 1;
    if (power_on_exit_req) n_por <= n_por + 1;
  end
endmodule : pwrt_far

//--- test/periodic_wakeup_reset_timer_tb_top.sv
// Register-level testbench for the periodic wakeup and reset timer
`timescale 1ns/1ps
module periodic_wakeup_reset_timer_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, other_reset, cg, pd, dbg;
  logic        wakeup_irq, prr, crq, poe, por_only, pready, pslverr, lfo_clk, last_err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0]  pstrb;
  int          errors, samples_checked, cyc;

  always #10 pclk = ~pclk;

  pwrt_top pwrt_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .lfo_clk(lfo_clk), .other_reset(other_reset),
    .clock_gated_stop_mode(cg), .power_down_stop_mode(pd), .background_debug_halt(dbg),
    .wakeup_irq(wakeup_irq), .periodic_reset_req(prr), .clock_restart_req(crq),
    .power_on_exit_req(poe), .system_reset_source_por_only(por_only));
  pwrt_far pwrt_far_inst (.pclk(pclk), .wakeup_irq(wakeup_irq), .periodic_reset_req(prr),
    .clock_restart_req(crq), .power_on_exit_req(poe), .lfo_clk(lfo_clk));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] st, output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 4'hF, rv);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 8'h00, 4'hF, rv);
    chk(rv, e);
  endtask : rd

  task automatic wt();
    int k;
    int n;
    k = pwrt_far_inst.n_irq;
    n = 0;
    while (pwrt_far_inst.n_irq == k && n < 9000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, n < 9000}, 32'h1);
  endtask : wt

  always @(posedge pclk) begin
    cyc++;
    if (cyc == 95000) begin
      errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {pclk, presetn, psel, penable, pwrite, other_reset, cg, pd, dbg} = 9'h000;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'hF;
    {errors, samples_checked, cyc} = 96'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h004, 32'h3F);
    rd(12'h008, 32'h00);
    rd(12'h010, 32'h00);
    chk({31'h0, last_err}, 32'h1);
    wr(12'h000, 8'h00);
    wr(12'h004, 8'h00);
    rd(12'h004, 32'h3F);
    wr(12'h000, 8'h01);
    wr(12'h00C, 8'h00);
    wr(12'h004, 8'h02);
    apb(1'b1, 12'h004, 8'h05, 4'h0, rv);
    rd(12'h004, 32'h02);
    wr(12'h008, 8'h80);
    wt();
    rd(12'h000, 32'h81);
    wr(12'h000, 8'h41);
    rd(12'h000, 32'h01);
    rd(12'h008, 32'h81);
    wr(12'h004, 8'h02);
    rd(12'h008, 32'h81);
    cg <= 1'b1;
    wt();
    chk(pwrt_far_inst.n_prr, 32'h1);
    chk(pwrt_far_inst.n_clk, 32'h2);
    rd(12'h004, 32'h82);
    rd(12'h008, 32'h80);
    wr(12'h004, 8'h82);
    rd(12'h004, 32'h82);
    cg <= 1'b0;
    wr(12'h000, 8'h41);
    wt();
    rd(12'h008, 32'h81);
    wr(12'h004, 8'h03);
    rd(12'h008, 32'h80);
    @(posedge pclk);
    other_reset <= 1'b1;
    @(posedge pclk);
    other_reset <= 1'b0;
    rd(12'h004, 32'hBF);
    rd(12'h000, 32'h3F);
    rd(12'h008, 32'h80);
    wr(12'h000, 8'h41);
    wr(12'h004, 8'h41);
    rd(12'h004, 32'h01);
    pd <= 1'b1;
    wt();
    pd <= 1'b0;
    chk(pwrt_far_inst.n_por, 32'h2);
    chk(pwrt_far_inst.n_prr, 32'h1);
    rd(12'h004, 32'h81);
    rd(12'h000, 32'h81);
    wr(12'h000, 8'h41);
    wr(12'h004, 8'h40);
    rd(12'h004, 32'h00);
    wt();
    chk(pwrt_far_inst.n_prr, 32'h1);
    wr(12'h000, 8'h41);
    dbg <= 1'b1;
    repeat (7000) @(posedge pclk);
    chk(pwrt_far_inst.n_irq, 32'h5);
    dbg <= 1'b0;
    wt();
    print_verdict();
  end
endmodule : periodic_wakeup_reset_timer_tb_top
